/* sim/pmic_cpu_model.sv */
`timescale 1ns/1ps
module pmic_cpu_model #(
  parameter int INSTR_CYCLES = 12
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // core status
  input  wire logic cpu_run,
  // cpu activity
  output logic      instr_done,
  output logic      machine_cycle,
  output logic      ram_wr_req,
  output logic      addr_phase,
  output logic      port0_drive_req,
  output logic      ale_run,
  output logic      prog_store_strobe_run
);
  logic [7:0] cnt_ff;

  // free running state counter, machine cycles tick even when the core sleeps
  always_ff @(posedge ref_clk) begin
    if (!rst_b || cnt_ff == 8'(INSTR_CYCLES - 1)) begin
      cnt_ff <= 8'h00;
    end else begin
      cnt_ff <= cnt_ff + 8'h01;
    end
  end

  // the core keeps asking for ram writes so any leak through the gate shows
  always_ff @(posedge ref_clk) begin
    instr_done <= cpu_run && (cnt_ff == 8'(INSTR_CYCLES - 1));
    machine_cycle <= (cnt_ff % 8'h06) == 8'h00;
    ram_wr_req <= rst_b;
    addr_phase <= cnt_ff[0];
    port0_drive_req <= cnt_ff[2];
    ale_run <= cnt_ff[1];
    prog_store_strobe_run <= ~cnt_ff[1];
  end
endmodule

/* sim/pmic_ctrl_bench.sv */
`timescale 1ns/1ps
module pmic_ctrl_bench;
  logic        ref_clk, rst_b, clk_en, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        osc_in, hw_reset_pin, ext_mem_mode, ext0_pin, ext1_pin, hit, bad;
  logic        timer0_req, timer1_req, serial_req, t2_ovf_set, t2_ext_set;
  logic        instr_done, machine_cycle, ram_wr_req, addr_phase, port0_drive_req;
  logic        ale_run, pss_run, cpu_run, periph_clk_en, osc_enable, ram_wr_en;
  logic        sfr_hold, sfr_reset, internal_clk, addr_latch, prog_store_strobe;
  logic        port0_oe, port2_addr_sel, ic_last, osc_last;
  logic [5:0]  irq_ack_req;
  logic [2:0]  osc_div;
  int          n_mismatch, cmp_count, ic_cnt, oc_cnt, a0, b0, d, k;

  pmic_ctrl pmic_ctrl_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .clk_en(clk_en), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .osc_in(osc_in), .hw_reset_pin(hw_reset_pin),
    .ext_mem_mode(ext_mem_mode), .ext0_pin(ext0_pin), .ext1_pin(ext1_pin),
    .timer0_req(timer0_req), .timer1_req(timer1_req), .serial_req(serial_req),
    .timer2_overflow_set(t2_ovf_set), .timer2_external_set(t2_ext_set),
    .instr_done(instr_done), .machine_cycle(machine_cycle), .ram_wr_req(ram_wr_req),
    .addr_phase(addr_phase), .port0_drive_req(port0_drive_req), .ale_run(ale_run),
    .prog_store_strobe_run(pss_run), .cpu_run(cpu_run), .periph_clk_en(periph_clk_en),
    .osc_enable(osc_enable), .ram_wr_en(ram_wr_en), .sfr_hold(sfr_hold),
    .sfr_reset(sfr_reset), .internal_clk(internal_clk), .irq_ack_req(irq_ack_req),
    .addr_latch(addr_latch), .prog_store_strobe(prog_store_strobe), .port0_oe(port0_oe),
    .port2_addr_sel(port2_addr_sel)
  );

  pmic_cpu_model pmic_cpu_model_i (
    .ref_clk(ref_clk), .rst_b(rst_b), .cpu_run(cpu_run), .instr_done(instr_done),
    .machine_cycle(machine_cycle), .ram_wr_req(ram_wr_req), .addr_phase(addr_phase),
    .port0_drive_req(port0_drive_req), .ale_run(ale_run), .prog_store_strobe_run(pss_run)
  );

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  // uneven duty oscillator, plus edge counters for the divider
  always @(posedge ref_clk) begin
    osc_div <= (osc_div == 3'd4) ? 3'd0 : osc_div + 3'd1;
    osc_in <= (osc_div < 3'd2);
    ic_last <= internal_clk;
    osc_last <= osc_in;
    if (internal_clk !== ic_last) ic_cnt++;
    if (osc_in && !osc_last) oc_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // one apb transfer, then one idle cycle
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20) begin
      n_mismatch++;
      finish_test();
    end
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    xfer(1'b1, a, wd);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(rd, e);
  endtask

  task automatic wait_mode(input logic [1:0] m);
    k = 0;
    do begin
      xfer(1'b0, pmic_pkg::STATUS_OFS, 32'h0);
      k++;
    end while (rd[1:0] !== m && k < 40);
    chk({30'h0, rd[1:0]}, {30'h0, m});
  endtask

  task automatic ack_is(input logic [7:0] en, input logic [5:0] e);
    wr(pmic_pkg::IRQ_EN_OFS, {24'h0, en});
    repeat (2) @(posedge ref_clk);
    chk({26'h0, irq_ack_req}, {26'h0, e});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    finish_test();
  end

  initial begin
    {psel, penable, pwrite, hw_reset_pin, ext0_pin, ext1_pin} = '0;
    {timer0_req, timer1_req, serial_req, t2_ovf_set, t2_ext_set} = '0;
    rst_b = 1'b0;
    clk_en = 1'b1;
    ext_mem_mode = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    osc_div = 3'd0;
    osc_in = 1'b0;
    repeat (5) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(posedge ref_clk);
    rdc(pmic_pkg::IRQ_EN_OFS, 32'h00);
    a0 = ic_cnt;
    b0 = oc_cnt;
    repeat (100) @(posedge ref_clk);
    d = (ic_cnt - a0) - (oc_cnt - b0);
    chk(32'(d >= -1 && d <= 1), 32'h1);
    // a frozen block ignores a flag set pulse
    clk_en <= 1'b0;
    t2_ovf_set <= 1'b1;
    repeat (3) @(posedge ref_clk);
    t2_ovf_set <= 1'b0;
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rdc(pmic_pkg::T2_FLAGS_OFS, 32'h0);
    wr(pmic_pkg::IRQ_EN_OFS, 32'hFFFF_FFFF);
    rdc(pmic_pkg::IRQ_EN_OFS, 32'hFF);
    rdc(8'h10, 32'h0);
    // every source pending, one enable at a time
    {ext0_pin, ext1_pin, timer0_req, timer1_req, serial_req} <= 5'h1F;
    wr(pmic_pkg::T2_FLAGS_OFS, 32'h1);
    repeat (8) @(posedge ref_clk);
    for (int i = 0; i < 6; i++) begin
      ack_is(8'h80 | 8'(1 << i), 6'(1 << i));
    end
    ack_is(8'h3F, 6'h00);
    ack_is(8'hC0, 6'h00);
    ack_is(8'hFF, 6'h3F);
    wr(pmic_pkg::T2_FLAGS_OFS, 32'h2);
    ack_is(8'hA0, 6'h20);
    rdc(pmic_pkg::T2_FLAGS_OFS, 32'h2);
    wr(pmic_pkg::T2_FLAGS_OFS, 32'h0);
    t2_ovf_set <= 1'b1;
    @(posedge ref_clk);
    t2_ovf_set <= 1'b0;
    t2_ext_set <= 1'b1;
    @(posedge ref_clk);
    t2_ext_set <= 1'b0;
    rdc(pmic_pkg::T2_FLAGS_OFS, 32'h3);
    wr(pmic_pkg::T2_FLAGS_OFS, 32'h0);
    {ext0_pin, ext1_pin, timer0_req, timer1_req, serial_req} <= 5'h00;
    repeat (8) @(posedge ref_clk);
    // idle, woken by timer 0
    wr(pmic_pkg::IRQ_EN_OFS, 32'h82);
    wr(pmic_pkg::PWR_CTRL_OFS, 32'h1);
    wait_mode(2'd1);
    chk({30'h0, cpu_run, periph_clk_en}, 32'h1);
    chk({28'h0, addr_latch, prog_store_strobe, port0_oe, port2_addr_sel}, 32'hD);
    wr(pmic_pkg::IRQ_EN_OFS, 32'h0);
    rdc(pmic_pkg::IRQ_EN_OFS, 32'h82);
    timer0_req <= 1'b1;
    wait_mode(2'd0);
    timer0_req <= 1'b0;
    // power-down wins over idle, timer cannot wake, ext0 can
    wr(pmic_pkg::IRQ_EN_OFS, 32'h83);
    wr(pmic_pkg::PWR_CTRL_OFS, 32'h3);
    wait_mode(2'd2);
    chk({31'h0, osc_enable}, 32'h0);
    chk({28'h0, addr_latch, prog_store_strobe, port0_oe, port2_addr_sel}, 32'h0);
    a0 = ic_cnt;
    timer0_req <= 1'b1;
    repeat (20) @(posedge ref_clk);
    chk(32'(ic_cnt - a0), 32'h0);
    rdc(pmic_pkg::STATUS_OFS, 32'h2);
    rdc(pmic_pkg::IRQ_EN_OFS, 32'h83);
    ext0_pin <= 1'b1;
    wait_mode(2'd0);
    chk({31'h0, osc_enable}, 32'h1);
    {ext0_pin, timer0_req} <= 2'b00;
    // hardware reset out of idle
    wr(pmic_pkg::IRQ_EN_OFS, 32'h15);
    wr(pmic_pkg::PWR_CTRL_OFS, 32'h1);
    wait_mode(2'd1);
    hw_reset_pin <= 1'b1; // held well past the register reset
    hit = 1'b0;
    bad = 1'b0;
    for (k = 0; k < 80 && !hit; k++) begin
      @(posedge ref_clk);
      if (ram_wr_en === 1'b1) bad = 1'b1;
      if (sfr_reset === 1'b1) hit = 1'b1;
    end
    chk({31'h0, hit}, 32'h1);
    chk(32'(k > 10 && k < 30), 32'h1);
    chk({31'h0, bad}, 32'h0);
    repeat (20) @(posedge ref_clk);
    hw_reset_pin <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rdc(pmic_pkg::IRQ_EN_OFS, 32'h00);
    wait_mode(2'd0);
    finish_test();
  end
endmodule

/* verilog/pmic_ctrl.sv */
// The implementer's own choices: the APB slave port and the register addresses.
`timescale 1ns/1ps
module pmic_ctrl (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_b,
  input  wire logic        clk_en,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // oscillator and pins
  input  wire logic        osc_in,
  input  wire logic        hw_reset_pin,
  input  wire logic        ext_mem_mode,
  input  wire logic        ext0_pin,
  input  wire logic        ext1_pin,
  // interrupt sources from on-chip logic
  input  wire logic        timer0_req,
  input  wire logic        timer1_req,
  input  wire logic        serial_req,
  input  wire logic        timer2_overflow_set,
  input  wire logic        timer2_external_set,
  // cpu side
  input  wire logic        instr_done,
  input  wire logic        machine_cycle,
  input  wire logic        ram_wr_req,
  input  wire logic        addr_phase,
  input  wire logic        port0_drive_req,
  input  wire logic        ale_run,
  input  wire logic        prog_store_strobe_run,
  output logic             cpu_run,
  output logic             periph_clk_en,
  output logic             osc_enable,
  output logic             ram_wr_en,
  output logic             sfr_hold,
  output logic             sfr_reset,
  output logic             internal_clk,
  output logic [5:0]       irq_ack_req,
  output logic             addr_latch,
  output logic             prog_store_strobe,
  output logic             port0_oe,
  output logic             port2_addr_sel
);
  ////////////////////////////////////////////////////////////////////////////
  logic [7:0]  irq_en_ff;
  logic [1:0]  pwr_ctrl_ff;
  logic        timer2_overflow_flag_ff;
  logic        timer2_external_flag_ff;
  logic        osc_div_ff;
  logic [3:0]  pins_sync;
  logic        osc_s;
  logic        osc_prev_ff;
  logic        ext0_s;
  logic        ext1_s;
  logic        hw_reset_s;
  logic        reset_seen_ff;
  logic [1:0]  resume_cnt_ff;
  logic        resume_ff;
  pmic_pkg::pmic_mode_t mode_ff;
  pmic_pkg::pmic_mode_t nxt_mode;
  logic [5:0]  src_req;
  logic [5:0]  src_en;
  logic        any_enabled;
  logic        ext_enabled;
  logic        wr_acc;
  logic        rd_acc;
  logic        in_hold;

  pmic_sync #(
    .W(4)
  ) u_sync (
    .ref_clk  (ref_clk),
    .rst_b    (rst_b),
    .clk_en   (clk_en),
    .async_in ({osc_in, hw_reset_pin, ext1_pin, ext0_pin}),
    .sync_out (pins_sync)
  );
  assign ext0_s     = pins_sync[0];
  assign ext1_s     = pins_sync[1];
  assign hw_reset_s = pins_sync[2];
  assign osc_s      = pins_sync[3];

  ////////////////////////////////////////////////////////////////////////////
  // interrupt qualification
  always_comb begin
    src_req = {timer2_overflow_flag_ff | timer2_external_flag_ff,
               serial_req, timer1_req, ext1_s, timer0_req, ext0_s};
    src_en  = {irq_en_ff[pmic_pkg::TIMER2_BIT], irq_en_ff[pmic_pkg::SERIAL_BIT],
               irq_en_ff[pmic_pkg::TIMER1_BIT], irq_en_ff[pmic_pkg::EXT1_BIT],
               irq_en_ff[pmic_pkg::TIMER0_BIT], irq_en_ff[pmic_pkg::EXT0_BIT]};
  end
  assign any_enabled = irq_en_ff[pmic_pkg::GLOBAL_BIT] & (|(src_req & src_en));
  assign ext_enabled = irq_en_ff[pmic_pkg::GLOBAL_BIT] &
                       ((ext0_s & irq_en_ff[pmic_pkg::EXT0_BIT]) |
                        (ext1_s & irq_en_ff[pmic_pkg::EXT1_BIT]));

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      irq_ack_req <= 6'h00;
    end else if (clk_en) begin
      irq_ack_req <= irq_en_ff[pmic_pkg::GLOBAL_BIT] ? (src_req & src_en) : 6'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave, zero wait states
  assign in_hold = (mode_ff != pmic_pkg::PMIC_RUN);
  assign wr_acc  = psel & penable & pwrite & clk_en;
  assign rd_acc  = psel & penable & ~pwrite & clk_en;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (clk_en) begin
      pready  <= psel & ~penable;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          pmic_pkg::IRQ_EN_OFS:   prdata <= {24'h000000, irq_en_ff};
          pmic_pkg::PWR_CTRL_OFS: prdata <= {30'h00000000, pwr_ctrl_ff};
          pmic_pkg::STATUS_OFS:   prdata <= {28'h0000000, resume_ff, 1'b0, mode_ff};
          pmic_pkg::T2_FLAGS_OFS: prdata <= {30'h00000000, timer2_external_flag_ff,
                                             timer2_overflow_flag_ff};
          default:                prdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // registers: hold while cpu sleeps, reload on reset
  always_ff @(posedge ref_clk) begin
    if (!rst_b || (clk_en && hw_reset_s)) begin
      irq_en_ff <= pmic_pkg::IRQ_EN_RST;
    end else if (clk_en && !in_hold && wr_acc && pready && paddr == pmic_pkg::IRQ_EN_OFS) begin
      irq_en_ff <= pwdata[7:0];
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b || (clk_en && hw_reset_s)) begin
      pwr_ctrl_ff <= 2'b00;
    end else if (clk_en) begin
      if (wr_acc && pready && !in_hold && paddr == pmic_pkg::PWR_CTRL_OFS) begin
        pwr_ctrl_ff <= pwdata[1:0];
      end else if (mode_ff == pmic_pkg::PMIC_RUN && nxt_mode != pmic_pkg::PMIC_RUN) begin
        pwr_ctrl_ff <= 2'b00;
      end
    end
  end

  // timer 2 flags: hardware set wins over software clear
  always_ff @(posedge ref_clk) begin
    if (!rst_b || (clk_en && hw_reset_s)) begin
      timer2_overflow_flag_ff <= 1'b0;
      timer2_external_flag_ff <= 1'b0;
    end else if (clk_en) begin
      if (wr_acc && pready && paddr == pmic_pkg::T2_FLAGS_OFS) begin
        timer2_overflow_flag_ff <= pwdata[0] | timer2_overflow_set;
        timer2_external_flag_ff <= pwdata[1] | timer2_external_set;
      end else begin
        timer2_overflow_flag_ff <= timer2_overflow_flag_ff | timer2_overflow_set;
        timer2_external_flag_ff <= timer2_external_flag_ff | timer2_external_set;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // clock divider
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      osc_div_ff   <= 1'b0;
      osc_prev_ff  <= 1'b0;
      internal_clk <= 1'b0;
    end else if (clk_en) begin
      osc_prev_ff <= osc_s;
      // one toggle per rising oscillator edge outside power-down, so its duty cycle cannot matter
      if (osc_s && !osc_prev_ff && mode_ff != pmic_pkg::PMIC_PD) begin
        osc_div_ff <= ~osc_div_ff;
      end
      internal_clk <= osc_div_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power mode machine
  always_comb begin
    nxt_mode = mode_ff;
    case (mode_ff)
      pmic_pkg::PMIC_RUN: begin
        if (instr_done && pwr_ctrl_ff[pmic_pkg::PD_REQ_BIT]) begin
          nxt_mode = pmic_pkg::PMIC_PD;
        end else if (instr_done && pwr_ctrl_ff[pmic_pkg::IDLE_REQ_BIT]) begin
          nxt_mode = pmic_pkg::PMIC_IDLE;
        end
      end
      pmic_pkg::PMIC_IDLE: begin
        if (any_enabled || hw_reset_s) begin
          nxt_mode = pmic_pkg::PMIC_RUN;
        end
      end
      pmic_pkg::PMIC_PD: begin
        if (ext_enabled || hw_reset_s) begin
          nxt_mode = pmic_pkg::PMIC_RUN;
        end
      end
      default: nxt_mode = pmic_pkg::PMIC_RUN;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      mode_ff <= pmic_pkg::PMIC_RUN;
    end else if (clk_en) begin
      mode_ff <= nxt_mode;
    end
  end

  // resumed window after reset ends idle
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      resume_ff     <= 1'b0;
      resume_cnt_ff <= 2'b00;
      reset_seen_ff <= 1'b0;
    end else if (clk_en) begin
      reset_seen_ff <= 1'b0;
      if (mode_ff == pmic_pkg::PMIC_IDLE && hw_reset_s) begin
        resume_ff     <= 1'b1;
        resume_cnt_ff <= 2'(pmic_pkg::RESUME_CYCLES);
      end else if (resume_ff && machine_cycle) begin
        resume_cnt_ff <= resume_cnt_ff - 2'b01;
        if (resume_cnt_ff == 2'b01) begin
          resume_ff     <= 1'b0;
          reset_seen_ff <= 1'b1;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // cpu and memory controls
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cpu_run       <= 1'b0;
      periph_clk_en <= 1'b0;
      osc_enable    <= 1'b1;
      ram_wr_en     <= 1'b0;
      sfr_hold      <= 1'b0;
      sfr_reset     <= 1'b1;
    end else if (clk_en) begin
      cpu_run       <= (nxt_mode == pmic_pkg::PMIC_RUN);
      periph_clk_en <= (nxt_mode != pmic_pkg::PMIC_PD);
      osc_enable    <= (nxt_mode != pmic_pkg::PMIC_PD);
      ram_wr_en     <= ram_wr_req && nxt_mode == pmic_pkg::PMIC_RUN &&
                       !resume_ff && !hw_reset_s;
      sfr_hold      <= (nxt_mode != pmic_pkg::PMIC_RUN);
      sfr_reset     <= (hw_reset_s && !resume_ff && mode_ff != pmic_pkg::PMIC_IDLE) ||
                       reset_seen_ff;
    end
  end

  // pin states per mode
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      addr_latch        <= 1'b1;
      prog_store_strobe <= 1'b1;
      port0_oe          <= 1'b0;
      port2_addr_sel    <= 1'b0;
    end else if (clk_en) begin
      case (nxt_mode)
        pmic_pkg::PMIC_IDLE: begin
          addr_latch        <= 1'b1;
          prog_store_strobe <= 1'b1;
          port0_oe          <= !ext_mem_mode;
          port2_addr_sel    <= ext_mem_mode;
        end
        pmic_pkg::PMIC_PD: begin
          addr_latch        <= 1'b0;
          prog_store_strobe <= 1'b0;
          port0_oe          <= !ext_mem_mode;
          port2_addr_sel    <= 1'b0;
        end
        default: begin
          addr_latch        <= ale_run;
          prog_store_strobe <= prog_store_strobe_run;
          port0_oe          <= port0_drive_req;
          port2_addr_sel    <= ext_mem_mode & addr_phase;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  a_global_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && !irq_en_ff[pmic_pkg::GLOBAL_BIT] |=> irq_ack_req == 6'h00)
    else $error("ack without global enable");

  a_timer_no_pd_wake: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && mode_ff == pmic_pkg::PMIC_PD && !ext_enabled && !hw_reset_s
    |=> mode_ff == pmic_pkg::PMIC_PD)
    else $error("power-down left without cause");

  a_idle_wake: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && mode_ff == pmic_pkg::PMIC_IDLE && any_enabled |=> mode_ff == pmic_pkg::PMIC_RUN)
    else $error("idle not left on interrupt");

  a_pd_strobes: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && mode_ff == pmic_pkg::PMIC_PD ##1 clk_en && mode_ff == pmic_pkg::PMIC_PD
    |-> !addr_latch && !prog_store_strobe)
    else $error("strobes not low in power-down");

  a_pd_osc_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && nxt_mode == pmic_pkg::PMIC_PD |=> !osc_enable && !cpu_run)
    else $error("oscillator runs in power-down");

  a_pd_priority: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && mode_ff == pmic_pkg::PMIC_RUN && instr_done && (&pwr_ctrl_ff)
    |=> mode_ff == pmic_pkg::PMIC_PD)
    else $error("power-down lost priority");

  a_resume_ram: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && resume_ff |=> !ram_wr_en)
    else $error("ram written in resume window");

  a_idle_periph: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && nxt_mode == pmic_pkg::PMIC_IDLE |=> periph_clk_en && !cpu_run)
    else $error("idle clocks wrong");

  a_hold_regs: assert property (@(posedge ref_clk) disable iff (!rst_b)
    clk_en && mode_ff == pmic_pkg::PMIC_IDLE && !hw_reset_s |=> $stable(irq_en_ff))
    else $error("enable register changed in idle");
endmodule

/* verilog/pmic_pkg.sv */
package pmic_pkg;
  // register byte addresses
  localparam logic [7:0] IRQ_EN_OFS    = 8'h00;
  localparam logic [7:0] PWR_CTRL_OFS  = 8'h04;
  localparam logic [7:0] STATUS_OFS    = 8'h08;
  localparam logic [7:0] T2_FLAGS_OFS  = 8'h0C;
  // enable register fields
  localparam int GLOBAL_BIT   = 7;
  localparam int RSVD_BIT     = 6;
  localparam int TIMER2_BIT   = 5;
  localparam int SERIAL_BIT   = 4;
  localparam int TIMER1_BIT   = 3;
  localparam int EXT1_BIT     = 2;
  localparam int TIMER0_BIT   = 1;
  localparam int EXT0_BIT     = 0;
  // power control fields
  localparam int IDLE_REQ_BIT = 0;
  localparam int PD_REQ_BIT   = 1;
  // reset values
  localparam logic [7:0] IRQ_EN_RST   = 8'h00;
  // cycles of resumed execution after reset ends idle
  localparam int RESUME_CYCLES = 2;
  typedef enum logic [1:0] {
    PMIC_RUN  = 2'b00,
    PMIC_IDLE = 2'b01,
    PMIC_PD   = 2'b10
  } pmic_mode_t;
endpackage

/* verilog/pmic_sync.sv */
`timescale 1ns/1ps
module pmic_sync #(
  parameter int W = 1
) (
  // clock
  input  wire logic         ref_clk,
  input  wire logic         rst_b,
  input  wire logic         clk_en,
  // data
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] s1_ff;
  logic [W-1:0] s2_ff;
  logic [W-1:0] s3_ff;

  // a change counts once the second and third stage agree
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      s1_ff    <= '0;
      s2_ff    <= '0;
      s3_ff    <= '0;
      sync_out <= '0;
    end else if (clk_en) begin
      s1_ff <= async_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      for (int i = 0; i < W; i++) begin
        if (s2_ff[i] == s3_ff[i]) begin
          sync_out[i] <= s3_ff[i];
        end
      end
    end
  end
endmodule
